// ### respwm_pkg.sv
package respwm_pkg;
   // clock and timing resolution
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_NS = 5;
   // 5 ns steps covered by one clock period
   localparam int TICK_UNITS = CLK_PERIOD_NS / STEP_NS;

   // register offsets, as byte addresses of the 8-bit register port
   localparam logic [7:0] ADDR_FREQ_SET = 8'h40;
   localparam logic [7:0] ADDR_MAXP_UPPER = 8'h42;
   localparam logic [7:0] ADDR_FALL_OFS = 8'h43;
   localparam logic [7:0] ADDR_MAXP_LOWER = 8'h44;
   localparam logic [7:0] ADDR_RISE_DLY = 8'h45;
   localparam logic [7:0] ADDR_STATUS = 8'h60;

   // field layouts
   localparam int FREQ_FIELD_W = 6;
   localparam logic [5:0] RESONANT_CODE = 6'h3F;
   localparam int MAXP_LOWER_LSB = 4;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_CLAMP_BIT = 1;

   // reset values
   localparam logic [7:0] RST_FREQ_SET = 8'h00;
   localparam logic [7:0] RST_MAXP_UPPER = 8'hFF;
   localparam logic [7:0] RST_MAXP_LOWER = 8'hF0;
   localparam logic [7:0] RST_FALL_OFS = 8'h00;
   localparam logic [7:0] RST_RISE_DLY = 8'h00;

   // one complete set of timing for a switching cycle
   typedef struct packed {
      logic [11:0] max_period;
      logic [7:0] fall_offset;
      logic [7:0] rise_delay;
   } timing_set_t;
endpackage

// ### cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
   parameter int POS_W = 13,
   parameter int PER_W = 12,
   parameter int STEP = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic [PER_W-1:0] period,
   // position in 5 ns units and end-of-cycle pulse
   output logic [POS_W-1:0] pos,
   output logic wrap
);
   logic [POS_W-1:0] pos_reg;
   logic [POS_W-1:0] pos_sum;

   // next position; wrap on the last clock whose end still fits the period,
   // so a cycle is period/STEP clocks rounded down and never overruns it
   assign pos_sum = pos_reg + POS_W'(STEP);
   assign wrap = run && (pos_sum + POS_W'(STEP) > {{(POS_W-PER_W){1'b0}}, period});
   assign pos = pos_reg;

   // position counter, parked at zero while idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_reg <= '0;
      end else if (!run || wrap) begin
         pos_reg <= '0;
      end else begin
         pos_reg <= pos_sum;
      end
   end
endmodule
`default_nettype wire

// ### resonant_pwm_timing.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - max period bits 11:4 come from the whole upper limit register
// - max period bits 3:0 come from lower limit bits 7:4; bits 3:0 reserved
// - one count of the 12-bit max period is 5 ns of cycle
// - in resonant mode no cycle lasts longer than the max period or one clock, whichever is longer
// - fall offset 0x00..0x7F puts first output fall 0..635 ns after mid-point
// - fall offset 0x80..0xFF puts the fall 640..5 ns before mid-point
// - second output rises code times 5 ns after cycle start
// - timing is used only while frequency field holds 0x3F
module resonant_pwm_timing
   import respwm_pkg::*;
#(
   parameter int PER_W = 12
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // period asked for by the regulation loop, 5 ns units
   input wire logic [PER_W-1:0] DESIRED_PERIOD,
   // gate drive outputs and cycle marker
   output logic FIRST_PHASE_OUTPUT,
   output logic SECOND_PHASE_OUTPUT,
   output logic CYCLE_START
);
   localparam int POS_W = PER_W + 1;

   logic [7:0] freq_set_reg;
   logic [7:0] maxp_upper_reg;
   logic [7:0] maxp_lower_reg;
   logic [7:0] fall_ofs_reg;
   logic [7:0] rise_dly_reg;
   logic [7:0] rdata_reg;
   timing_set_t cfg_next;
   timing_set_t shadow_reg;
   logic [PER_W-1:0] period_reg;
   logic [PER_W-1:0] period_next;
   logic clamp_reg;
   logic run_reg;
   logic res_mode;
   logic load;
   logic wrap;
   logic [POS_W-1:0] pos;
   logic signed [13:0] fall_pt;
   logic first_on;
   logic second_on;
   logic first_reg;
   logic second_reg;
   logic start_reg;

   // address match, shared by the write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   // software registers
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         freq_set_reg <= RST_FREQ_SET;
         maxp_upper_reg <= RST_MAXP_UPPER;
         maxp_lower_reg <= RST_MAXP_LOWER;
         fall_ofs_reg <= RST_FALL_OFS;
         rise_dly_reg <= RST_RISE_DLY;
      end else if (REG_WR) begin
         if (hit(REG_ADDR, ADDR_FREQ_SET)) freq_set_reg <= REG_WDATA;
         if (hit(REG_ADDR, ADDR_MAXP_UPPER)) maxp_upper_reg <= REG_WDATA;
         if (hit(REG_ADDR, ADDR_MAXP_LOWER)) maxp_lower_reg <= REG_WDATA;
         if (hit(REG_ADDR, ADDR_FALL_OFS)) fall_ofs_reg <= REG_WDATA;
         if (hit(REG_ADDR, ADDR_RISE_DLY)) rise_dly_reg <= REG_WDATA;
      end
   end

   // read data one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= 8'h00;
      end else if (REG_RD) begin
         if (hit(REG_ADDR, ADDR_FREQ_SET)) rdata_reg <= freq_set_reg;
         else if (hit(REG_ADDR, ADDR_MAXP_UPPER)) rdata_reg <= maxp_upper_reg;
         else if (hit(REG_ADDR, ADDR_MAXP_LOWER)) rdata_reg <= maxp_lower_reg;
         else if (hit(REG_ADDR, ADDR_FALL_OFS)) rdata_reg <= fall_ofs_reg;
         else if (hit(REG_ADDR, ADDR_RISE_DLY)) rdata_reg <= rise_dly_reg;
         else if (hit(REG_ADDR, ADDR_STATUS)) begin
            rdata_reg <= 8'h00;
            rdata_reg[STAT_RUN_BIT] <= run_reg;
            rdata_reg[STAT_CLAMP_BIT] <= clamp_reg;
         end else rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign REG_RDATA = rdata_reg;

   // assemble the timing set; the reserved low nibble is kept but unused
   always_comb begin
      cfg_next.max_period = {maxp_upper_reg, maxp_lower_reg[7:MAXP_LOWER_LSB]};
      cfg_next.fall_offset = fall_ofs_reg;
      cfg_next.rise_delay = rise_dly_reg;
   end

   // resonant mode select
   assign res_mode = freq_set_reg[FREQ_FIELD_W-1:0] == RESONANT_CODE;

   // cycle length: loop request clamped to the limit, floored to one clock
   always_comb begin
      period_next = DESIRED_PERIOD;
      if (DESIRED_PERIOD > cfg_next.max_period) begin
         period_next = cfg_next.max_period;
      end
      if (period_next < PER_W'(TICK_UNITS)) begin
         period_next = PER_W'(TICK_UNITS);
      end
   end

   // a cycle starts on entry into resonant mode or at each wrap
   assign load = res_mode && (!run_reg || wrap);

   // settings are sampled only at the boundary so a cycle never mixes them
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         shadow_reg <= '0;
         period_reg <= PER_W'(TICK_UNITS);
         clamp_reg <= 1'b0;
      end else if (load) begin
         shadow_reg <= cfg_next;
         period_reg <= period_next;
         clamp_reg <= DESIRED_PERIOD > cfg_next.max_period;
      end
   end

   // run state follows the mode; leaving it stops the cycle at once
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= res_mode;
      end
   end

   cycle_timer #(
      .POS_W(POS_W),
      .PER_W(PER_W),
      .STEP(TICK_UNITS)
   ) u_timer (
      .clk(REF_CLK),
      .rst_n(RESET_N),
      .run(run_reg && res_mode),
      .period(period_reg),
      .pos(pos),
      .wrap(wrap)
   );

   // fall point: mid-point plus the signed offset; a point at or before the start keeps the output low all cycle
   assign fall_pt = $signed({3'b000, period_reg[PER_W-1:1]})
      + $signed({{6{shadow_reg.fall_offset[7]}}, shadow_reg.fall_offset});
   assign first_on = fall_pt > $signed({1'b0, pos});
   // second output waits out its delay; resolution is one clock, not 5 ns
   assign second_on = {{(POS_W-8){1'b0}}, shadow_reg.rise_delay} <= pos;

   // registered gate drive, forced low outside resonant mode
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         first_reg <= 1'b0;
         second_reg <= 1'b0;
         start_reg <= 1'b0;
      end else begin
         first_reg <= res_mode && run_reg && first_on;
         second_reg <= res_mode && run_reg && second_on;
         start_reg <= load;
      end
   end
   assign FIRST_PHASE_OUTPUT = first_reg;
   assign SECOND_PHASE_OUTPUT = second_reg;
   assign CYCLE_START = start_reg;

   // helper: clocks since the last cycle start
   logic [PER_W-1:0] cyc_cnt;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cyc_cnt <= '0;
      end else if (load || !run_reg) begin
         cyc_cnt <= '0;
      end else begin
         cyc_cnt <= cyc_cnt + PER_W'(1);
      end
   end

   sequence s_wr_upper;
      REG_WR && REG_ADDR == ADDR_MAXP_UPPER;
   endsequence
   sequence s_wr_lower;
      REG_WR && REG_ADDR == ADDR_MAXP_LOWER;
   endsequence

   AST_UPPER_BYTE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s_wr_upper |=> cfg_next.max_period[11:4] == $past(REG_WDATA))
      else $error("upper limit byte not in period bits 11:4");
   AST_LOWER_NIBBLE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      s_wr_lower |=> cfg_next.max_period[3:0] == $past(REG_WDATA[7:4]))
      else $error("lower limit nibble not in period bits 3:0");
   AST_CYCLE_LENGTH: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      run_reg |-> (int'(cyc_cnt) + 1) * TICK_UNITS <= int'(period_reg))
      else $error("cycle ran past its period");
   AST_PERIOD_LIMIT: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      load |=> period_reg <= $past(cfg_next.max_period) || period_reg == PER_W'(TICK_UNITS))
      else $error("period exceeds the programmed maximum");
   AST_FALL_TRAIL: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      res_mode && run_reg && !shadow_reg.fall_offset[7]
      && pos < {2'b00, period_reg[PER_W-1:1]} |=> FIRST_PHASE_OUTPUT)
      else $error("first output fell before the mid-point");
   AST_FALL_LEAD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      res_mode && run_reg && shadow_reg.fall_offset[7]
      && pos >= {2'b00, period_reg[PER_W-1:1]} |=> !FIRST_PHASE_OUTPUT)
      else $error("first output still high after the mid-point");
   AST_RISE_DELAY: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      $rose(SECOND_PHASE_OUTPUT) |-> $past(pos) >= {5'h00, $past(shadow_reg.rise_delay)})
      else $error("second output rose before its delay");
   AST_MODE_GATE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      !res_mode |=> !FIRST_PHASE_OUTPUT && !SECOND_PHASE_OUTPUT && !CYCLE_START && !run_reg)
      else $error("outputs active outside resonant mode");
   AST_SHADOW_HOLD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      !load |=> $stable(shadow_reg) && $stable(period_reg))
      else $error("timing changed inside a cycle");
endmodule
`default_nettype wire

// ### gate_drv_model.sv
`timescale 1ns/1ps
`default_nettype none
module gate_drv_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // gate drive inputs and cycle marker
   input wire logic gate_a,
   input wire logic gate_b,
   input wire logic cyc_start,
   // figures of the last whole cycle, in clocks
   output int len,
   output int hi_a,
   output int hi_b
);
   int c_len;
   int c_a;
   int c_b;

   // integrate on-time per gate; one marker to the next is exactly one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {c_len, c_a, c_b, len, hi_a, hi_b} <= '0;
      end else if (cyc_start) begin
         len <= c_len;
         hi_a <= c_a;
         hi_b <= c_b;
         c_len <= 1;
         c_a <= int'(gate_a);
         c_b <= int'(gate_b);
      end else begin
         c_len <= c_len + 1;
         c_a <= c_a + int'(gate_a);
         c_b <= c_b + int'(gate_b);
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import respwm_pkg::*;
   logic ref_clk, reset_n, reg_wr, reg_rd, out_a, out_b, cyc_st;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [11:0] des;
   logic [31:0] seed = 32'h0000EC6B;
   logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'hF0, 8'h00};
   logic [7:0] ot [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
   logic [7:0] dt [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};
   int len, hi_a, hi_b, n_mismatch, tests_run;

   resonant_pwm_timing uut (.REF_CLK(ref_clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .DESIRED_PERIOD(des), .FIRST_PHASE_OUTPUT(out_a), .SECOND_PHASE_OUTPUT(out_b),
      .CYCLE_START(cyc_st));
   gate_drv_model gdm (.clk(ref_clk), .rst_n(reset_n), .gate_a(out_a), .gate_b(out_b),
      .cyc_start(cyc_st), .len(len), .hi_a(hi_a), .hi_b(hi_b));

   // xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // reference model: clocks per cycle and on-clocks per gate
   function automatic int cyc(int p);
      return p / 4;
   endfunction
   function automatic int exp_a(int p, logic [7:0] o);
      int t;
      t = p / 2 + int'($signed(o));
      return (t <= 0) ? 0 : (((t + 3) / 4 > cyc(p)) ? cyc(p) : (t + 3) / 4);
   endfunction
   function automatic int exp_b(int p, int d);
      return ((d + 3) / 4 > cyc(p)) ? 0 : cyc(p) - (d + 3) / 4;
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // read data is looked at only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(16'(reg_rdata), 16'(e));
   endtask
   // wait for n cycle markers; the model has latched the cycle on return
   task automatic sync(input int n);
      int g;
      g = 0;
      repeat (n) begin
         do begin
            @(posedge ref_clk);
            #1;
            g++;
         end while (cyc_st !== 1'b1 && g < 5000);
      end
      @(posedge ref_clk);
      #1;
   endtask
   // four markers so the latched window holds only new settings
   task automatic go(input logic [7:0] up, lo, o, dl, input logic [11:0] d);
      int pp;
      pp = (d < {up, lo[7:4]}) ? int'(d) : int'({up, lo[7:4]});
      pp = (pp < 4) ? 4 : pp;
      wr(ADDR_MAXP_UPPER, up);
      wr(ADDR_MAXP_LOWER, lo);
      wr(ADDR_FALL_OFS, o);
      wr(ADDR_RISE_DLY, dl);
      @(posedge ref_clk);
      des <= d;
      sync(4);
      chk(16'(len), 16'(cyc(pp)));
      chk(16'(hi_a), 16'(exp_a(pp, o)));
      chk(16'(hi_b), 16'(exp_b(pp, int'(dl))));
   endtask

   task automatic tally_and_finish();
      if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // a hang is cut at well over the expected run length
   initial begin
      repeat (40000) @(posedge ref_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, des} = '0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      // reset values; the gap at 0x41 answers zero
      for (int i = 0; i < 6; i++) rdchk(8'(8'h40 + i), rv[i]);
      wr(ADDR_MAXP_LOWER, 8'hA5);
      rdchk(ADDR_MAXP_LOWER, 8'hA5);
      wr(ADDR_FREQ_SET, 8'h3F);
      // offset and delay extremes with the loop asking beyond the limit
      for (int i = 0; i < 4; i++) go(8'h41, 8'h00, ot[i], dt[i], 12'hFFF);
      // random limits, periods and offsets
      for (int i = 0; i < 6; i++) begin
         go(8'(rnd() % 12 + 1), 8'(rnd()), 8'(rnd()), 8'(rnd()), 12'(rnd() % 256));
      end
      // limit rewritten mid-cycle must not touch the running cycle
      go(8'h20, 8'h00, 8'h00, 8'h00, 12'hFFF);
      sync(1);
      wr(ADDR_MAXP_UPPER, 8'h04);
      wr(ADDR_MAXP_LOWER, 8'h00);
      sync(1);
      chk(16'(len), 16'd128);
      sync(2);
      chk(16'(len), 16'd16);
      // status: running, last load clamped to the limit
      rdchk(ADDR_STATUS, 8'h03);
      // any other frequency code stops both gates
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_FREQ_SET, (i == 0) ? 8'h00 : ((i == 1) ? 8'h3E : 8'h1F));
         repeat (4) @(posedge ref_clk);
         #1;
         chk(16'({out_a, out_b}), 16'h0000);
      end
      rdchk(ADDR_STATUS, 8'h02);
      // reserved upper bits set must not hide the resonant code
      wr(ADDR_FREQ_SET, 8'hFF);
      sync(1);
      rdchk(ADDR_STATUS, 8'h03);
      tally_and_finish();
   end
endmodule
`default_nettype wire
